//--- core/hcs_regs.vh
// register map, field layout, reset values and timing counts of the sealing-cycle sequencer
`ifndef HCS_REGS_VH
`define HCS_REGS_VH
`define HCS_CTRL_OFS 8'h00
`define HCS_DELAY_OFS 8'h04
`define HCS_SEAL_OFS 8'h08
`define HCS_COOL_OFS 8'h0C
`define HCS_TEMP_OFS 8'h10
`define HCS_STATUS_OFS 8'h14
`define HCS_ACT_OFS 8'h18
`define HCS_CTRL_TIMER_LSB 0
`define HCS_CTRL_EXT_BIT 2
`define HCS_CTRL_COOLMODE_LSB 3
`define HCS_CTRL_SEALSTART_BIT 5
`define HCS_CTRL_BRIGHT_LSB 6
`define HCS_CTRL_RST 32'h0000_0080
`define HCS_TIMER_OFF 2'h0
`define HCS_TIMER_ON 2'h1
`define HCS_TIMER_MON 2'h2
`define HCS_COOL_ABS 2'h0
`define HCS_COOL_REL 2'h1
`define HCS_COOL_TIME 2'h2
`define HCS_DELAY_RST 10'h000
`define HCS_DELAY_MAX 10'h063
`define HCS_SEAL_RST 10'h00A
`define HCS_SEAL_MAX 10'h3E7
`define HCS_COOL_ABS_RST 10'h032
`define HCS_COOL_REL_RST 10'h028
`define HCS_COOL_REL_MAX 10'h064
`define HCS_COOL_TIME_RST 10'h064
`define HCS_COOL_TIME_MAX 10'h3E7
`define HCS_TEMP_MAX_RST 10'h12C
`define HCS_CLK_HZ 25000000
`define HCS_TICK_NS 100000000
`define HCS_INIT_MS 500
`define HCS_REACH_PCT 95
`define HCS_ANALOG_ZERO 10'h000
`endif

//--- core/hcs_sequencer.v
// sealing-cycle sequencer with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "hcs_regs.vh"
// Behaviour
// - home keys step brightness four levels, 75% default
// - undervoltage enters standby, no cycles, no pulses
// - voltage back in tolerance leaves standby
// - standby keeps alarm off, analog output zero
// - timer mode off, on, or monitored
// - start launches timeout; reset aborts it
// - monitored mode aborts when start drops early
// - order is delay, heating, cooling, relay; relay here is on during heating and cooling
// - manual heat key never launches timeout
// - home shows countdown and phase marker
// - marker clears at end; icon follows relay
// - starting delay 0 to 9.9 s, default zero
// - fixed sealing time 0 to 99.9 s, 1.0 default
// - external mode seals while start held
// - absolute cooling ends below cooling temperature
// - absolute cooling temperature at least 50 C
// - relative cooling ends at percent of set
// - relative percent 40 to 100, default 40
// - time cooling 0 to 99.9 s, default 10.0
// - cooling mode change overwrites cooling value
// - sealing time starts at 95% or heating start
// - 500 ms initialisation after reset refuses cycles
module hcs_sequencer #(
  parameter integer INIT_CYCLES = `HCS_CLK_HZ / 1000 * `HCS_INIT_MS,
  parameter integer TICK_CYCLES = `HCS_CLK_HZ / (1000000000 / `HCS_TICK_NS)
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire start,
  input wire cycle_reset,
  input wire manual_heat_key,
  input wire key_up,
  input wire key_down,
  input wire home_position,
  input wire undervoltage,
  input wire [9:0] actual_temp,
  output reg heat_enable,
  output reg measure_enable,
  output reg cycle_relay,
  output reg relay_icon,
  output reg standby,
  output reg alarm_relay,
  output reg [9:0] analog_out,
  output reg [1:0] glow_display,
  output reg [1:0] phase_marker,
  output reg [9:0] remaining_time
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DELAY = 5'h02;
  localparam [4:0] ST_HEAT = 5'h04;
  localparam [4:0] ST_COOL = 5'h08;
  localparam [4:0] ST_INIT = 5'h10;

  reg [4:0] state;
  reg [31:0] ctrl;
  reg [9:0] delay_set;
  reg [9:0] seal_set;
  reg [9:0] cool_set;
  reg [9:0] temp_set;
  reg [9:0] count;
  reg [31:0] init_count;
  reg start_d;
  reg up_d;
  reg down_d;
  reg seal_running;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire tick;
  wire start_rise;
  wire [1:0] timer_mode;
  wire [1:0] cool_mode;
  wire ext_mode;
  wire seal_at_reach;
  wire reached;
  wire cool_done;
  wire phase_restart;
  wire wr_go;
  wire [31:0] wr_val;

  assign timer_mode = ctrl[`HCS_CTRL_TIMER_LSB +: 2];
  assign ext_mode = ctrl[`HCS_CTRL_EXT_BIT];
  assign cool_mode = ctrl[`HCS_CTRL_COOLMODE_LSB +: 2];
  assign seal_at_reach = !ctrl[`HCS_CTRL_SEALSTART_BIT];
  assign start_rise = start && !start_d;

  // clamp a written value into its legal range
  function [9:0] clamp;
    input [31:0] val;
    input [9:0] lo;
    input [9:0] hi;
    begin
      if (val < {22'h000000, lo}) begin
        clamp = lo;
      end else if (val > {22'h000000, hi}) begin
        clamp = hi;
      end else begin
        clamp = val[9:0];
      end
    end
  endfunction

  // merge write data into an old word under the byte strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // default cooling value for each mode
  function [9:0] cool_default;
    input [1:0] mode;
    begin
      case (mode)
        `HCS_COOL_REL: cool_default = `HCS_COOL_REL_RST;
        `HCS_COOL_TIME: cool_default = `HCS_COOL_TIME_RST;
        default: cool_default = `HCS_COOL_ABS_RST;
      endcase
    end
  endfunction

  // 95 percent of set; wide math avoids overflow
  assign reached = ({12'h000, actual_temp} * 22'd100) >=
                   ({12'h000, temp_set} * `HCS_REACH_PCT);
  assign cool_done =
    (cool_mode == `HCS_COOL_TIME) ? (count == 10'h000) :
    (cool_mode == `HCS_COOL_REL) ?
      (({12'h000, actual_temp} * 22'd100) <=
       ({12'h000, temp_set} * {12'h000, cool_set})) :
      (actual_temp < cool_set);
  assign phase_restart = start_rise && state == ST_IDLE;

  hcs_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .restart(phase_restart),
    .tick(tick)
  );

  // AXI4-Lite: address and data latch in either order, one write at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_val = merge(32'h0000_0000, w_data, w_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `HCS_ACT_OFS || aw_addr[1:0] != 2'h0 ||
                        aw_addr == `HCS_STATUS_OFS ||
                        aw_addr == `HCS_ACT_OFS) ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `HCS_CTRL_OFS: s_axi_rdata <= ctrl;
          `HCS_DELAY_OFS: s_axi_rdata <= {22'h000000, delay_set};
          `HCS_SEAL_OFS: s_axi_rdata <= {22'h000000, seal_set};
          `HCS_COOL_OFS: s_axi_rdata <= {22'h000000, cool_set};
          `HCS_TEMP_OFS: s_axi_rdata <= {22'h000000, temp_set};
          `HCS_STATUS_OFS: s_axi_rdata <= {19'h00000, standby, cycle_relay,
                                          phase_marker, state, count[3:0]};
          `HCS_ACT_OFS: s_axi_rdata <= {22'h000000, remaining_time};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // configuration registers; keys step brightness only in cycles without a bus write
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `HCS_CTRL_RST;
      delay_set <= `HCS_DELAY_RST;
      seal_set <= `HCS_SEAL_RST;
      cool_set <= `HCS_COOL_ABS_RST;
      temp_set <= `HCS_TEMP_MAX_RST;
      up_d <= 1'b0;
      down_d <= 1'b0;
    end else if (ce) begin
      up_d <= key_up;
      down_d <= key_down;
      if (wr_go) begin
        case (aw_addr)
          `HCS_CTRL_OFS: begin
            ctrl <= {24'h000000, wr_val[7:0]};
            if (wr_val[`HCS_CTRL_COOLMODE_LSB +: 2] != cool_mode) begin
              cool_set <= cool_default(
                wr_val[`HCS_CTRL_COOLMODE_LSB +: 2]);
            end
          end
          `HCS_DELAY_OFS: delay_set <= clamp(wr_val, 10'h000,
                                             `HCS_DELAY_MAX);
          `HCS_SEAL_OFS: seal_set <= clamp(wr_val, 10'h000,
                                           `HCS_SEAL_MAX);
          `HCS_COOL_OFS: begin
            case (cool_mode)
              `HCS_COOL_REL: cool_set <= clamp(wr_val, `HCS_COOL_REL_RST,
                                             `HCS_COOL_REL_MAX);
              `HCS_COOL_TIME: cool_set <= clamp(wr_val, 10'h000,
                                            `HCS_COOL_TIME_MAX);
              default: cool_set <= clamp(wr_val, `HCS_COOL_ABS_RST,
                                         temp_set);
            endcase
          end
          `HCS_TEMP_OFS: temp_set <= wr_val[9:0];
          default: ;
        endcase
      end else if (home_position) begin
        if (key_up && !up_d && ctrl[7:6] != 2'h3) begin
          ctrl[7:6] <= ctrl[7:6] + 2'h1;
        end else if (key_down && !down_d && ctrl[7:6] != 2'h0) begin
          ctrl[7:6] <= ctrl[7:6] - 2'h1;
        end
      end
    end
  end

  // cycle sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_INIT;
      init_count <= 32'h0000_0000;
      count <= 10'h000;
      start_d <= 1'b0;
      seal_running <= 1'b0;
    end else if (ce) begin
      start_d <= start;
      case (state)
        ST_INIT: begin
          // new cycles refused until settled
          if (cycle_reset) begin
            init_count <= 32'h0000_0000;
          end else if (init_count == INIT_CYCLES - 1) begin
            state <= ST_IDLE;
          end else begin
            init_count <= init_count + 32'h0000_0001;
          end
        end
        ST_IDLE: begin
          if (cycle_reset) begin
            state <= ST_INIT;
            init_count <= 32'h0000_0000;
          end else if (start_rise && !undervoltage &&
                       timer_mode != `HCS_TIMER_OFF) begin
            state <= ST_DELAY;
            count <= delay_set;
          end
        end
        default: begin
          if (cycle_reset || undervoltage ||
              (timer_mode == `HCS_TIMER_MON && !start)) begin
            state <= cycle_reset ? ST_INIT : ST_IDLE;
            init_count <= 32'h0000_0000;
            seal_running <= 1'b0;
          end else if (state == ST_DELAY) begin
            if (count == 10'h000) begin
              state <= ST_HEAT;
              count <= seal_set;
              seal_running <= !seal_at_reach;
            end else if (tick) begin
              count <= count - 10'h001;
            end
          end else if (state == ST_HEAT) begin
            if (seal_at_reach && reached) begin
              seal_running <= 1'b1;
            end
            if (ext_mode ? !start :
                (seal_running && count == 10'h000)) begin
              state <= ST_COOL;
              count <= cool_set;
              seal_running <= 1'b0;
            end else if (tick && seal_running && !ext_mode &&
                         count != 10'h000) begin
              count <= count - 10'h001;
            end
          end else begin
            if (cool_done) begin
              state <= ST_IDLE;
            end else if (tick && count != 10'h000) begin
              count <= count - 10'h001;
            end
          end
        end
      endcase
    end
  end

  // outputs from flip-flops; standby overrides heating, pulses, relay, icon and analog output
  always @(posedge aclk) begin
    if (!aresetn) begin
      heat_enable <= 1'b0;
      measure_enable <= 1'b0;
      cycle_relay <= 1'b0;
      relay_icon <= 1'b0;
      standby <= 1'b0;
      alarm_relay <= 1'b0;
      analog_out <= `HCS_ANALOG_ZERO;
      glow_display <= 2'h2;
      phase_marker <= 2'h0;
      remaining_time <= 10'h000;
    end else if (ce) begin
      standby <= undervoltage;
      alarm_relay <= 1'b0;
      glow_display <= ctrl[7:6];
      measure_enable <= !undervoltage && !cycle_reset;
      analog_out <= (undervoltage || cycle_reset) ?
                    `HCS_ANALOG_ZERO : actual_temp;
      // manual key heats only, no timeout
      heat_enable <= !undervoltage && !cycle_reset &&
                     (state == ST_HEAT ||
                      (manual_heat_key && state == ST_IDLE));
      cycle_relay <= !undervoltage &&
                     (state == ST_HEAT || state == ST_COOL);
      relay_icon <= !undervoltage &&
                    (state == ST_HEAT || state == ST_COOL);
      phase_marker <= (state == ST_DELAY || state == ST_HEAT) ? 2'h1 :
                      (state == ST_COOL) ? 2'h2 : 2'h0;
      remaining_time <= (state == ST_HEAT && !ext_mode) ?
                        count : 10'h000;
    end
  end
  // standby exits by itself when undervoltage clears
endmodule
`default_nettype wire

//--- core/hcs_tick.v
// divider that produces the 0.1 s phase tick; the settle delay after reset is counted in the sequencer
`timescale 1ns/100ps
`default_nettype none
module hcs_tick #(
  parameter integer TICK_CYCLES = 2500000
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire restart,
  output reg tick
);
  reg [31:0] count;
  // restart aligns the tick to a cycle start so the delay phase sees full ticks
  always @(posedge aclk) begin
    if (!aresetn) begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (ce) begin
      if (restart || count == TICK_CYCLES - 1) begin
        count <= 32'h0000_0000;
      end else begin
        count <= count + 32'h0000_0001;
      end
      tick <= !restart && (count == TICK_CYCLES - 1);
    end
  end
endmodule
`default_nettype wire

//--- tb/hcs_ctrl_model.sv
// higher-level controller model driving the start and abort lines
`timescale 1ns/100ps
`default_nettype none
module hcs_ctrl_model (
  input wire logic aclk,
  output logic start,
  output logic cycle_reset
);
  initial begin
    start = 1'b0;
    cycle_reset = 1'b0;
  end
  // a monitored cycle lives only while start is held; an external-length sealing phase ends when start drops
  task automatic drive(input logic s, r, input int n);
    start <= s;
    cycle_reset <= r;
    repeat (n) @(posedge aclk);
    start <= 1'b0;
    cycle_reset <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/hcs_props.sv
// concurrent checks on the sealing-cycle sequencer ports
`timescale 1ns/100ps
`default_nettype none
module hcs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic undervoltage,
  input wire logic key_up,
  input wire logic home_position,
  input wire logic heat_enable,
  input wire logic measure_enable,
  input wire logic cycle_relay,
  input wire logic relay_icon,
  input wire logic standby,
  input wire logic alarm_relay,
  input wire logic [9:0] analog_out,
  input wire logic [1:0] glow_display,
  input wire logic [1:0] phase_marker,
  input wire logic [9:0] remaining_time
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_up_from_mid;
    home_position && $rose(key_up) && glow_display == 2'h2;
  endsequence
  sequence s_cool_left;
    $past(phase_marker) == 2'h2 && phase_marker != 2'h2;
  endsequence
  property p_icon; relay_icon == cycle_relay; endproperty
  a_icon: assert property (p_icon) else $error("icon off relay");
  property p_alarm; !alarm_relay; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm set");
  property p_uv_out; undervoltage [*2] |=> analog_out == 10'h000; endproperty
  a_uv_out: assert property (p_uv_out) else $error("analog live");
  property p_standby; 1'b1 |=> standby == $past(undervoltage); endproperty
  a_standby: assert property (p_standby) else $error("standby");
  property p_measure; undervoltage [*3] |-> !measure_enable; endproperty
  a_measure: assert property (p_measure) else $error("pulses on");
  property p_cool; phase_marker == 2'h2 && !standby |-> cycle_relay &&
    !heat_enable;
  endproperty
  a_cool: assert property (p_cool) else $error("cooling heats");
  property p_order; s_cool_left |-> phase_marker == 2'h0; endproperty
  a_order: assert property (p_order) else $error("cool exit bad");
  property p_glow_rst; $rose(aresetn) |-> glow_display == 2'h2; endproperty
  a_glow_rst: assert property (p_glow_rst) else $error("glow");
  property p_glow_up; s_up_from_mid |-> ##[1:3] glow_display == 2'h3;
  endproperty
  a_glow_up: assert property (p_glow_up) else $error("no step");
  property p_idle_time;
    phase_marker == 2'h0 && $past(phase_marker) == 2'h0 |->
      remaining_time == 10'h000;
  endproperty
  a_idle_time: assert property (p_idle_time) else $error("idle");
endmodule
bind hcs_sequencer hcs_props u_props (.aclk, .aresetn, .undervoltage,
  .key_up, .home_position, .heat_enable, .measure_enable, .cycle_relay,
  .relay_icon, .standby, .alarm_relay, .analog_out, .glow_display,
  .phase_marker, .remaining_time);
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the sealing-cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic manual_heat_key = 1'b0, key_up = 1'b0, key_down = 1'b0;
  logic home_position = 1'b0, undervoltage = 1'b0;
  logic [9:0] actual_temp = 10'h000;
  logic ce = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [9:0] rmax;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, start, cycle_reset, heat_enable, measure_enable;
  wire cycle_relay, relay_icon, standby, alarm_relay;
  wire [1:0] s_axi_bresp, s_axi_rresp, glow_display, phase_marker;
  wire [31:0] s_axi_rdata;
  wire [9:0] analog_out, remaining_time;
  int n_fail = 0, checked = 0, cyc = 0;
  int d, h, c, m, q;
  logic [31:0] cm[3] = '{32'h88, 32'h90, 32'h80};
  logic [31:0] cd[3] = '{32'h28, 32'h64, 32'h32};
  logic [31:0] ch[3] = '{32'h64, 32'h3E7, 32'h12C};
  logic [31:0] cl[3] = '{32'h28, 32'h0, 32'h32};
  logic [31:0] ac[2] = '{32'hA1, 32'hA9};
  logic [31:0] av[2] = '{32'h64, 32'h3C};
  logic [9:0] ts[2] = '{10'h064, 10'h0B5};
  // short counts keep the run small: 4 cycles a tick, 50 cycles settle
  hcs_sequencer #(.INIT_CYCLES(50), .TICK_CYCLES(4)) dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .start,
    .cycle_reset, .manual_heat_key, .key_up, .key_down, .home_position,
    .undervoltage, .actual_temp, .heat_enable, .measure_enable,
    .cycle_relay, .relay_icon, .standby, .alarm_relay, .analog_out,
    .glow_display, .phase_marker, .remaining_time);
  hcs_ctrl_model ctl (.aclk, .start, .cycle_reset);
  initial begin
    forever #20 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("checked %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rng(input string nm, input int v, lo, hi);
    checked++;
    if (v < lo || v > hi) begin
      n_fail++;
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  // ready lines are combinational, so they are judged at the edge itself
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ev,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata, ev);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic key(input logic u, dn, hp, input logic [1:0] e);
    key_up <= u;
    key_down <= dn;
    home_position <= hp;
    @(posedge aclk);
    key_up <= 1'b0;
    key_down <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("glow", {30'h0, glow_display}, {30'h0, e});
  endtask
  task automatic watch();
    d = 0;
    h = 0;
    c = 0;
    rmax = 10'h000;
    do begin
      @(posedge aclk);
      if (phase_marker == 2'h1 && heat_enable !== 1'b1) d++;
      else if (heat_enable === 1'b1) h++;
      else if (phase_marker == 2'h2) c++;
      if (remaining_time > rmax) rmax = remaining_time;
    end while (phase_marker !== 2'h0 || d + h + c == 0);
  endtask
  task automatic quiet(input int n);
    m = 0;
    q = 0;
    repeat (n) begin
      @(posedge aclk);
      if (phase_marker !== 2'h0) m++;
      if (heat_enable === 1'b1) q++;
    end
  endtask
  task automatic run(input logic [31:0] cr, dl, sl, cv, input int hold, at,
                     input logic [9:0] tv);
    wr(8'h00, cr, 2'h0);
    wr(8'h04, dl, 2'h0);
    wr(8'h08, sl, 2'h0);
    wr(8'h0C, cv, 2'h0);
    fork
      watch();
      ctl.drive(1'b1, 1'b0, hold);
      begin
        repeat (at) @(posedge aclk);
        actual_temp <= tv;
      end
    join
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h80, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h08, 32'hA, 2'h0);
    rd(8'h0C, 32'h32, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    wr(8'h04, 32'h7D0, 2'h0);
    rd(8'h04, 32'h63, 2'h0);
    // only the low byte lands, so the clamp sees 0x12
    s_axi_wstrb <= 4'h1;
    wr(8'h04, 32'h512, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, 32'h12, 2'h0);
    wr(8'h08, 32'h7D0, 2'h0);
    rd(8'h08, 32'h3E7, 2'h0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, cm[i], 2'h0);
      rd(8'h0C, cd[i], 2'h0);
      wr(8'h0C, 32'h7D0, 2'h0);
      rd(8'h0C, ch[i], 2'h0);
      wr(8'h0C, 32'h0, 2'h0);
      rd(8'h0C, cl[i], 2'h0);
    end
    $display("test registers done");
    key(1'b1, 1'b0, 1'b1, 2'h3);
    key(1'b1, 1'b0, 1'b1, 2'h3);
    key(1'b0, 1'b1, 1'b1, 2'h2);
    key(1'b0, 1'b1, 1'b1, 2'h1);
    key(1'b0, 1'b1, 1'b1, 2'h0);
    key(1'b0, 1'b1, 1'b1, 2'h0);
    key(1'b1, 1'b0, 1'b0, 2'h0);
    // clock enable low: the key edge must be lost while all other state holds
    ce <= 1'b0;
    key(1'b1, 1'b0, 1'b1, 2'h0);
    ce <= 1'b1;
    $display("test brightness done");
    run(32'hB1, 32'h2, 32'h3, 32'h3, 2, 0, 10'h064);
    // two ticks of 4 cycles plus one tick and one hand-over cycle of latency
    rng("delay", d, 9, 11);
    rng("heat", h, 11, 13);
    rng("cool", c, 11, 13);
    chk("countdown", {22'h0, rmax}, 32'h3);
    run(32'hB1, 32'h0, 32'h3, 32'h3, 2, 0, 10'h064);
    rng("no_delay", d, 0, 2);
    actual_temp <= 10'h11C;
    run(32'h91, 32'h0, 32'h3, 32'h3, 2, 30, 10'h11D);
    rng("reach", h, 37, 47);
    run(32'hB5, 32'h0, 32'h32, 32'h3, 20, 0, 10'h11D);
    rng("ext_len", h, 17, 22);
    run(32'hB2, 32'h0, 32'h32, 32'h32, 10, 0, 10'h11D);
    rng("monitor", d + h + c, 9, 13);
    $display("test cycles done");
    wr(8'h00, 32'hB1, 2'h0);
    fork
      watch();
      begin
        ctl.drive(1'b1, 1'b0, 2);
        repeat (8) @(posedge aclk);
        ctl.drive(1'b0, 1'b1, 3);
      end
    join
    rng("abort", d + h + c, 9, 13);
    @(posedge aclk);
    fork
      quiet(40);
      ctl.drive(1'b1, 1'b0, 2);
    join
    chk("settle", m, 32'h0);
    repeat (20) @(posedge aclk);
    manual_heat_key <= 1'b1;
    quiet(10);
    manual_heat_key <= 1'b0;
    chk("manual_cycle", m, 32'h0);
    rng("manual_heat", q, 7, 10);
    $display("test abort done");
    for (int i = 0; i < 2; i++) begin
      actual_temp <= ts[i];
      run(ac[i], 32'h0, 32'h1, av[i], 2, 20, ts[i] - 10'h001);
      rng("cool_temp", d + h + c, 20, 24);
    end
    $display("test cooling done");
    undervoltage <= 1'b1;
    fork
      quiet(20);
      ctl.drive(1'b1, 1'b0, 2);
    join
    chk("uv_cycle", m, 32'h0);
    chk("standby", {31'h0, standby}, 32'h1);
    chk("measure", {31'h0, measure_enable}, 32'h0);
    chk("alarm", {31'h0, alarm_relay}, 32'h0);
    chk("analog", {22'h0, analog_out}, 32'h0);
    undervoltage <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("standby", {31'h0, standby}, 32'h0);
    chk("analog", {22'h0, analog_out}, {22'h0, actual_temp});
    run(32'hB1, 32'h0, 32'h1, 32'h1, 2, 0, 10'h0B4);
    rng("resume", h, 1, 8);
    $display("test undervoltage done");
    finish_test();
  end
endmodule
`default_nettype wire
